/* src/backlight_enable_mtp_protect.sv */
/*
 * working register image, non-volatile store copy and protection decisions.
 * assumes an i2c slave front end giving byte write/read strobes, analog
 * comparator outputs on pins, and sys_rst acting as power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none
module backlight_enable_mtp_protect
    import backlight_pkg::*;
#(
    parameter int channels = channel_count
) (
    // clocking
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                clk_en,
    // register port from i2c slave
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    output logic                     reg_rvalid,
    // analog comparator pins
    input  wire logic                enable_pin,
    input  wire logic                vin_uvlo,
    input  wire logic [channels-1:0] feedback_open,
    input  wire logic [channels-1:0] feedback_above_ovp,
    input  wire logic [channels-1:0] channel_short,
    input  wire logic                vout_above_limit,
    input  wire logic                temp_above_upper,
    input  wire logic                temp_above_lower,
    // controls
    output logic [channels-1:0]      channel_sink_on,
    output logic [channels-1:0]      min_select_mask,
    output logic                     power_switch_on,
    output logic                     store_busy,
    output logic                     thermal_shutdown,
    output logic                     short_latched
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // pin map, register fields and checker all assume six strings
    if (channels != channel_count) begin : g_bad_channels
        $error("channels must equal six");
    end
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // all pins share one filter instance; the packing order fixes the slices below
    localparam int pin_w = 3 * channels + 5;
    logic [pin_w-1:0] pins_s;
    pin_sync #(.width(pin_w)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .pin_in  ({enable_pin, vin_uvlo, feedback_open, feedback_above_ovp,
                   channel_short, vout_above_limit, temp_above_upper, temp_above_lower}),
        .pin_out (pins_s)
    );
    wire                en_s    = pins_s[pin_w-1];
    wire                uvlo_s  = pins_s[pin_w-2];
    wire [channels-1:0] open_s  = pins_s[3*channels+2 : 2*channels+3];
    wire [channels-1:0] ovp_s   = pins_s[2*channels+2 : channels+3];
    wire [channels-1:0] short_s = pins_s[channels+2 : 3];
    wire                vout_s  = pins_s[2];
    wire                hot_s   = pins_s[1];
    wire                warm_s  = pins_s[0];
    // ------------------------------------------------------------
    // register image and store
    // ------------------------------------------------------------
    localparam logic [7:0] last_ptr = 8'(reg_count - 1);
    logic [7:0]   image [reg_count];
    // the store keeps its words through reset; at first power it holds the
    // image defaults and zero everywhere else
    logic [7:0]   store [reg_count] = '{
        addr_backlight_channel_enable: rst_backlight_channel_enable,
        default:                       8'h00
    };
    store_state_e state;
    logic [7:0]   ptr;
    logic         read_select;
    wire          in_run    = (state == st_run);
    wire          last_word = (ptr == last_ptr);
    wire [7:0]    next_ptr  = in_run ? 8'h00 : ptr + 8'h01;
    wire          ctl_hit   = (reg_addr == addr_nonvolatile_store_control);
    wire          host_wr   = reg_wr & in_run;
    wire          prog_req  = host_wr & ctl_hit & reg_wdata[bit_store_program];
    // the control word reads back busy in place of the program bit
    wire [7:0]    ctl_word  = {store_busy, 6'h00, read_select};
    wire [7:0]    rd_word   = ctl_hit ? ctl_word :
                              (read_select ? store[reg_addr] : image[reg_addr]);
    wire [7:0]    chan_reg  = image[addr_backlight_channel_enable];
    wire          master_en = chan_reg[bit_backlight_master_enable];
    wire [channels-1:0] chan_en = chan_reg[bit_channel_lo +: channels];

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    store_state_e next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            st_load:    if (last_word) next_state = st_run;
            st_run:     if (prog_req) next_state = st_program;
            st_program: if (last_word) next_state = st_run;
            default:    next_state = st_load;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer: load after reset, program on request
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state       <= st_load;
            ptr         <= 8'h00;
            read_select <= rst_nonvolatile_store_control[bit_store_read_select];
            store_busy  <= 1'b1;
        end else if (clk_en) begin
            state      <= next_state;
            ptr        <= next_ptr;
            store_busy <= (next_state != st_run);
            if (host_wr && ctl_hit) begin
                read_select <= reg_wdata[bit_store_read_select];
            end
        end
    end
    // ------------------------------------------------------------
    // read port: one registered answer per read strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            reg_rdata  <= rd_word;
        end
    end
    // ------------------------------------------------------------
    // image and store words
    // ------------------------------------------------------------
    // host writes are dropped while busy so a copy never sees a half-updated image
    always_ff @(posedge clk) begin
        if (clk_en) begin
            if (state == st_load) begin
                image[ptr] <= store[ptr];
            end else if (host_wr && !ctl_hit) begin
                image[reg_addr] <= reg_wdata;
            end
            if (state == st_program) begin
                store[ptr] <= image[ptr];
            end
        end
    end
    // ------------------------------------------------------------
    // string selection
    // ------------------------------------------------------------
    logic                hot;
    wire                 active = master_en & in_run & ~hot & ~short_latched;
    wire [channels-1:0]  used;
    wire [channels-1:0]  above;
    wire [channels-1:0]  shorted;
    wire [channels-1:0]  next_sink;
    // an unused string must not hold the minimum down, so it counts as above
    for (genvar c = 0; c < channels; c++) begin : g_chan
        assign used[c]      = chan_en[c] & ~open_s[c];
        assign above[c]     = ovp_s[c] | ~used[c];
        assign shorted[c]   = short_s[c] & used[c];
        assign next_sink[c] = active & used[c];
    end
    // ------------------------------------------------------------
    // protection decisions
    // ------------------------------------------------------------
    wire                 any_used  = |used;
    wire                 all_open  = ~any_used;
    wire                 min_above = any_used & (&above);
    wire                 short_hit = |shorted;
    wire                 clamp     = all_open ? vout_s : min_above;
    // hysteresis: set above the upper level, held until below the lower one
    wire                 next_hot  = hot_s | (hot & warm_s);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hot              <= 1'b0;
            thermal_shutdown <= 1'b0;
            short_latched    <= 1'b0;
            channel_sink_on  <= '0;
            min_select_mask  <= '0;
            power_switch_on  <= 1'b0;
        end else if (clk_en) begin
            hot              <= next_hot;
            thermal_shutdown <= next_hot;
            // a clear request beats a new short in the same cycle
            if (!en_s || uvlo_s) begin
                short_latched <= 1'b0;
            end else if (active && short_hit) begin
                short_latched <= 1'b1;
            end
            channel_sink_on  <= next_sink;
            min_select_mask  <= used;
            power_switch_on  <= active & ~clamp;
        end
    end
endmodule
`default_nettype wire

/* src/backlight_pkg.sv */
/*
 * shared constants for the backlight enable, store and protection block.
 * assumes a byte-wide register port fed by an i2c slave front end.
 */
`default_nettype none
package backlight_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] addr_backlight_channel_enable  = 8'h0b;
    localparam logic [7:0] addr_nonvolatile_store_control = 8'hff;
    localparam logic [7:0] addr_protection_config         = 8'h0a;
    localparam int         reg_count                      = 256;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int bit_backlight_master_enable = 7;
    localparam int bit_channel_lo              = 1;
    localparam int bit_store_program           = 7;
    localparam int bit_store_read_select       = 0;
    localparam int bit_ovp_level_lo            = 5;
    localparam int channel_count               = 6;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] rst_backlight_channel_enable  = 8'hfe;
    localparam logic [7:0] rst_nonvolatile_store_control = 8'h00;
    // ------------------------------------------------------------
    // timing: one register word moved per cycle, pin filter depth
    // ------------------------------------------------------------
    localparam int sync_stages = 3;
    typedef enum logic [2:0] {
        st_load    = 3'b001,
        st_run     = 3'b010,
        st_program = 3'b100
    } store_state_e;
endpackage
`default_nettype wire

/* src/pin_sync.sv */
/*
 * three-stage synchroniser with agreement filter for a bus of pins.
 * assumes clk is the device clock; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int width = 1
) (
    // clocking
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // pins
    input  wire logic [width-1:0] pin_in,
    output var  logic [width-1:0] pin_out
);
    logic [width-1:0] s1;
    logic [width-1:0] s2;
    logic [width-1:0] s3;
    wire  [width-1:0] agree = ~(s2 ^ s3);
    wire  [width-1:0] next_out = (agree & s3) | (~agree & pin_out);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1      <= '0;
            s2      <= '0;
            s3      <= '0;
            pin_out <= '0;
        end else if (clk_en) begin
            s1      <= pin_in;
            s2      <= s1;
            s3      <= s2;
            pin_out <= next_out;
        end
    end
endmodule
`default_nettype wire

/* testbench/backlight_enable_mtp_protect_tb_top.sv */
/* bench top: reset, enables, store copy and protection tests.
   assumes the host model and the port checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module backlight_enable_mtp_protect_tb_top;
    import backlight_pkg::*;
    localparam int channels = 6;
    logic       clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, enable_pin = 1'b1, vin_uvlo = 1'b0;
    logic       vout_above_limit = 1'b0, temp_above_upper = 1'b0, temp_above_lower = 1'b0;
    logic [5:0] feedback_open = '0, feedback_above_ovp = '0, channel_short = '0;
    logic       reg_wr, reg_rd, reg_rvalid, power_switch_on, store_busy, thermal_shutdown, short_latched;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, r, v;
    logic [5:0] channel_sink_on, min_select_mask;
    int         n_mismatch = 0, samples_checked = 0;
    backlight_enable_mtp_protect #(.channels(channels)) dut_u (.*);
    backlight_host_model host_u (.*);
    initial forever #4 clk = ~clk;
    function automatic logic [7:0] exp_sink(logic [7:0] cfg, logic [5:0] op);
        return {2'b00, cfg[7] ? cfg[6:1] & ~op : 6'h00};
    endfunction
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic settle();
        repeat (7) @(posedge clk);
        #1;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 300 && store_busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (store_busy !== 1'b0) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    initial begin
        void'($urandom(32'h0374a57c));
        repeat (12) @(posedge clk);
        #1 sys_rst = 1'b0;
        host_u.wr(addr_backlight_channel_enable, 8'h00);
        wait_idle();
        host_u.rd(addr_backlight_channel_enable, r);
        chk("ch_en reset", 8'hfe, r);
        host_u.rd(addr_nonvolatile_store_control, r);
        chk("store ctl reset", 8'h00, r);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h7e : (i == 1) ? 8'h80 : 8'($urandom) & 8'hfe;
            host_u.wr(addr_backlight_channel_enable, v & 8'h7e);
            host_u.wr(addr_backlight_channel_enable, v);
            host_u.rd(addr_backlight_channel_enable, r);
            chk("ch_en", v, r);
            settle();
            chk("sinks", exp_sink(v, 6'h00), {2'b00, channel_sink_on});
        end
        $display("enable test done");
        host_u.wr(addr_nonvolatile_store_control, 8'h01);
        host_u.rd(addr_backlight_channel_enable, r);
        chk("store read", 8'hfe, r);
        host_u.wr(addr_nonvolatile_store_control, 8'h80);
        chk("busy", 8'h01, {7'h00, store_busy});
        wait_idle();
        host_u.wr(addr_nonvolatile_store_control, 8'h01);
        host_u.rd(addr_backlight_channel_enable, r);
        chk("store copy", v, r);
        host_u.wr(addr_nonvolatile_store_control, 8'h00);
        host_u.wr(addr_backlight_channel_enable, 8'hfe);
        $display("store test done");
        for (int i = 0; i < 5; i++) begin
            feedback_open = (i == 4) ? 6'h00 : 6'($urandom);
            settle();
            chk("open sinks", exp_sink(8'hfe, feedback_open), {2'b00, channel_sink_on});
            chk("min mask", {2'b00, 6'h3f & ~feedback_open}, {2'b00, min_select_mask});
        end
        feedback_above_ovp = 6'h3f;
        settle();
        chk("led ovp", 8'h00, {7'h00, power_switch_on});
        feedback_above_ovp = 6'h01 << ($urandom % 6);
        settle();
        chk("led ovp one", 8'h01, {7'h00, power_switch_on});
        {feedback_above_ovp, feedback_open} = {6'h01, 6'h3e};
        settle();
        chk("ovp open", 8'h00, {7'h00, power_switch_on});
        {feedback_above_ovp, feedback_open, vout_above_limit} = {6'h00, 6'h3f, 1'b1};
        settle();
        chk("clamp", 8'h00, {7'h00, power_switch_on});
        {feedback_open, vout_above_limit} = 7'h00;
        settle();
        chk("switch back", 8'h01, {7'h00, power_switch_on});
        $display("protection test done");
        {temp_above_upper, temp_above_lower} = 2'b11;
        settle();
        chk("hot", 8'h01, {7'h00, thermal_shutdown});
        chk("hot sinks", 8'h00, {2'b00, channel_sink_on});
        temp_above_upper = 1'b0;
        settle();
        chk("cooling", 8'h01, {7'h00, thermal_shutdown});
        temp_above_lower = 1'b0;
        settle();
        chk("cool sinks", 8'h3f, {2'b00, channel_sink_on});
        for (int i = 0; i < 2; i++) begin
            channel_short = 6'h01 << ($urandom % 6);
            settle();
            channel_short = 6'h00;
            settle();
            chk("short held", 8'h01, {7'h00, short_latched});
            {enable_pin, vin_uvlo} = (i == 0) ? 2'b00 : 2'b11;
            settle();
            chk("short clear", 8'h00, {7'h00, short_latched});
            {enable_pin, vin_uvlo} = 2'b10;
            settle();
            chk("short resume", 8'h3f, {2'b00, channel_sink_on});
        end
        $display("fault test done");
        report_and_stop();
    end
endmodule
bind backlight_enable_mtp_protect backlight_monitor #(.channels(channels)) mon_u (.*);
`default_nettype wire

/* testbench/backlight_host_model.sv */
/* host model: byte write and read strobes toward the block.
   assumes strobes are taken on clk rising edges, answer one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module backlight_host_model (
    // clock
    input  wire logic       clk,
    // strobes, address and data toward the block
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    // read answer
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    // address and data are inverted once released so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk);
        #1 {reg_rd, reg_addr} = {1'b0, ~a};
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule
`default_nettype wire

/* testbench/backlight_monitor.sv */
/* port checker for the backlight block: read answers, store load and
   programming, protection decisions. assumes clk_en is held high. */
`timescale 1ns/1ps
`default_nettype none
module backlight_monitor
    import backlight_pkg::*;
#(
    parameter int channels = channel_count
) (
    // clocking and register port
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic                reg_rvalid,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    // comparator pins
    input wire logic                enable_pin,
    input wire logic                vin_uvlo,
    input wire logic                vout_above_limit,
    input wire logic                temp_above_upper,
    input wire logic                temp_above_lower,
    input wire logic [channels-1:0] feedback_open,
    input wire logic [channels-1:0] feedback_above_ovp,
    // controls
    input wire logic [channels-1:0] channel_sink_on,
    input wire logic                power_switch_on,
    input wire logic                store_busy,
    input wire logic                thermal_shutdown,
    input wire logic                short_latched
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // pin held long enough to pass the synchroniser and the output register
    sequence held7(s); s[*7]; endsequence
    sequence loading; store_busy throughout ##250 1'b1; endsequence
    rd_answer_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer wrong");
    load_done_a: assert property ($fell(sys_rst) |-> loading ##[1:10] !store_busy)
        else $error("store load length wrong");
    prog_start_a: assert property (reg_wr && !store_busy && reg_addr == addr_nonvolatile_store_control
        && reg_wdata[bit_store_program] |=> store_busy) else $error("programming not started");
    open_off_a: assert property (held7(feedback_open[0]) |-> !channel_sink_on[0])
        else $error("open channel driven");
    ovp_off_a: assert property (held7(&feedback_above_ovp && channel_sink_on[0]) |-> !power_switch_on)
        else $error("switch on above led limit");
    all_open_a: assert property (held7(&feedback_open && vout_above_limit) |-> !power_switch_on)
        else $error("output not clamped");
    hot_off_a: assert property (held7(temp_above_upper) |-> thermal_shutdown)
        else $error("no thermal shutdown");
    cool_on_a: assert property (held7(!temp_above_lower) |-> !thermal_shutdown)
        else $error("thermal shutdown stuck");
    short_clear_a: assert property (held7(!enable_pin || vin_uvlo) |-> !short_latched)
        else $error("short latch not cleared");
    short_off_a: assert property (short_latched[*2] |-> channel_sink_on == '0)
        else $error("sinks on while short latched");
endmodule
`default_nettype wire
